// *** channel_telemetry_readout.sv ***
// per-channel current and voltage telemetry behind a two-wire serial slave
// How it works
// RL1 - each channel keeps a 14-bit unsigned current result in bits 13..0
// RL2 - while powered, current result refreshes about every 100 ms
// RL3 - current count weighs 89.5 uA, full scale 1.46 A over 14 bits
// RL4 - current reads zero in off mode or idle semiauto without valid detection
// RL5 - manual mode keeps last value once detect/class was ever enabled; the code keeps it in manual mode without tracking whether it ever was
// RL6 - a finished classification measurement loads the class current
// RL7 - class current stays until powered conversion or port disable
// RL8 - class current weighs 8.95 uA per count; host applies that
// RL9 - voltage results sit at codes 32h, 36h, 3Ah, 3Eh, two bytes
// RL10 - two-byte reads go low byte first; writes change nothing
// RL11 - voltage results hold 14 bits in 13..0, reset to zero
// RL12 - current results sit at codes 30h, 34h, 38h, 3Ch, two bytes
// RL13 - voltage count weighs 3.662 mV, 60 V full scale when powered
// RL14 - top two bits of every high byte read zero
// RL15 - both bytes of one read come from one snapshot
`timescale 1ns/10ps

module channel_telemetry_readout #(
  parameter int         NUM_CH         = 4,
  parameter logic [6:0] SLAVE_ADDR     = 7'h20,
  parameter int         REFRESH_CYCLES = telemetry_pkg::REFRESH_CYCLES
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_n_out,
  input  wire telemetry_pkg::chan_ctrl_t [NUM_CH-1:0] ctrl_in,
  input  wire telemetry_pkg::chan_meas_t [NUM_CH-1:0] meas_in,
  output logic [NUM_CH-1:0]             class_scale_out,
  output logic                          refresh_tick_out
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > 4)
  begin : g_bad_ch
    $error("NUM_CH must be 1 to 4");
  end
  if (REFRESH_CYCLES < 2)
  begin : g_bad_ref
    $error("REFRESH_CYCLES must be at least 2");
  end

  localparam int RW = telemetry_pkg::RESULT_W;

  // ---------------------------------------------------------------
  // refresh timer
  // ---------------------------------------------------------------
  logic [31:0] ref_cnt_q;
  logic        tick_q;

  // free-running period counter for the powered conversions
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ref_cnt_q <= 32'h0;
      tick_q    <= 1'b0;
    end
    else if (ref_cnt_q == 32'(REFRESH_CYCLES - 1))
    begin
      ref_cnt_q <= 32'h0;
      tick_q    <= 1'b1; // [RL2]
    end
    else
    begin
      ref_cnt_q <= ref_cnt_q + 32'h1;
      tick_q    <= 1'b0;
    end
  end

  assign refresh_tick_out = tick_q;

  // ---------------------------------------------------------------
  // per-channel result registers
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0][RW-1:0] cur_q;
  logic [NUM_CH-1:0][RW-1:0] volt_q;
  logic [NUM_CH-1:0]         cls_q;
  logic [NUM_CH-1:0][RW-1:0] cur_view;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    telemetry_pkg::chan_ctrl_t ct;
    logic                      upd;
    logic                      blank;
    assign ct  = ctrl_in[c];
    assign upd = tick_q && ct.powered;

    // powered conversion wins over a class result in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        cur_q[c] <= RW'(telemetry_pkg::RESULT_RESET); // [RL1]
        cls_q[c] <= 1'b0;
      end
      else if (!ct.port_en)
      begin
        cur_q[c] <= RW'(telemetry_pkg::RESULT_RESET); // [RL7]
        cls_q[c] <= 1'b0;
      end
      else if (upd)
      begin
        cur_q[c] <= meas_in[c].cur; // [RL2] [RL3]
        cls_q[c] <= 1'b0;           // [RL7]
      end
      else if (meas_in[c].cls_done)
      begin
        cur_q[c] <= meas_in[c].cls; // [RL6]
        cls_q[c] <= 1'b1;           // [RL8]
      end
    end

    // voltage result, refreshed with the current while powered
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
        volt_q[c] <= RW'(telemetry_pkg::RESULT_RESET); // [RL11]
      else if (upd)
        volt_q[c] <= meas_in[c].volt; // [RL13]
    end

    // off and idle semiauto blank the reading; manual keeps it
    assign blank = (ct.mode == telemetry_pkg::MODE_OFF) ||
                   ((ct.mode == telemetry_pkg::MODE_SEMI) && !ct.powered &&
                    (!ct.detclass_en || !ct.det_valid)); // [RL4]
    assign cur_view[c] = blank ? '0 : cur_q[c]; // [RL5]
  end

  assign class_scale_out = cls_q; // [RL8]

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  localparam logic [7:0] CUR_OFS [4] = '{
    telemetry_pkg::CH1_CURRENT_OFS, telemetry_pkg::CH2_CURRENT_OFS,
    telemetry_pkg::CH3_CURRENT_OFS, telemetry_pkg::CH4_CURRENT_OFS};
  localparam logic [7:0] VOLT_OFS [4] = '{
    telemetry_pkg::CH1_VOLTAGE_OFS, telemetry_pkg::CH2_VOLTAGE_OFS,
    telemetry_pkg::CH3_VOLTAGE_OFS, telemetry_pkg::CH4_VOLTAGE_OFS};

  logic [7:0]  cmd_q;
  logic [15:0] sel_word;

  // unknown codes read as zero; upper two bits are always zero
  always_comb
  begin
    sel_word = {8'h00, telemetry_pkg::UNMAPPED_VAL};
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (cmd_q == CUR_OFS[i])
        sel_word = {2'b00, cur_view[i]};  // [RL12] [RL14]
      if (cmd_q == VOLT_OFS[i])
        sel_word = {2'b00, volt_q[i]};    // [RL9] [RL14]
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_d1_q;
  logic       sda_d1_q;

  // two flops per pin, a third stage for edges
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_d1_q   <= 1'b1;
      sda_d1_q   <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_d1_q   <= scl_sync_q[1];
      sda_d1_q   <= sda_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s && !scl_d1_q;
  assign scl_fall  = !scl_s && scl_d1_q;
  assign start_det = scl_s && scl_d1_q && sda_d1_q && !sda_s;
  assign stop_det  = scl_s && scl_d1_q && !sda_d1_q && sda_s;

  // ---------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------
  telemetry_pkg::ser_state_t state_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shreg_q;
  logic [7:0]  tx_q;
  logic [15:0] snap_q;
  logic        hi_byte_q;
  logic        rd_q;
  logic        nack_q;
  logic        drive_low_q;

  // phase and byte sequencing; bits move on scl edges
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q   <= telemetry_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shreg_q   <= 8'h00;
      tx_q      <= 8'h00;
      snap_q    <= telemetry_pkg::RESULT_RESET;
      hi_byte_q <= 1'b0;
      rd_q      <= 1'b0;
      nack_q    <= 1'b0;
      cmd_q     <= 8'h00;
    end
    else if (start_det)
    begin
      state_q   <= telemetry_pkg::ST_ADDR;
      bit_cnt_q <= 4'hF; // the start's own scl fall wraps this to zero
      hi_byte_q <= 1'b0;
      nack_q    <= 1'b0;
    end
    else if (stop_det)
      state_q <= telemetry_pkg::ST_IDLE;
    else if (scl_rise && state_q != telemetry_pkg::ST_IDLE)
    begin
      if (bit_cnt_q < 4'h8)
        shreg_q <= {shreg_q[6:0], sda_s};
      else if (state_q == telemetry_pkg::ST_RDATA)
        nack_q <= sda_s;
    end
    else if (scl_fall && state_q != telemetry_pkg::ST_IDLE)
    begin
      if (bit_cnt_q < 4'h8 || bit_cnt_q == 4'hF)
      begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        tx_q      <= {tx_q[6:0], 1'b0};
        if (bit_cnt_q == 4'h7 && state_q == telemetry_pkg::ST_ADDR)
          rd_q <= shreg_q[0];
      end
      else
      begin
        bit_cnt_q <= 4'h0;
        unique case (state_q)
          telemetry_pkg::ST_ADDR:
          begin
            if (shreg_q[7:1] != SLAVE_ADDR)
              state_q <= telemetry_pkg::ST_IDLE;
            else if (rd_q)
            begin
              // low byte first, high byte from the same snapshot
              state_q   <= telemetry_pkg::ST_RDATA;
              snap_q    <= sel_word;     // [RL15]
              tx_q      <= sel_word[7:0]; // [RL10]
              hi_byte_q <= 1'b1;
            end
            else
              state_q <= telemetry_pkg::ST_CMD;
          end
          telemetry_pkg::ST_CMD:
          begin
            cmd_q   <= shreg_q;
            state_q <= telemetry_pkg::ST_WDATA;
          end
          telemetry_pkg::ST_WDATA:
            state_q <= telemetry_pkg::ST_WDATA; // [RL10] data dropped
          telemetry_pkg::ST_RDATA:
          begin
            if (nack_q)
              state_q <= telemetry_pkg::ST_IDLE;
            else if (hi_byte_q)
            begin
              tx_q      <= snap_q[15:8]; // [RL10] [RL15]
              hi_byte_q <= 1'b0;
            end
            else
            begin
              snap_q    <= sel_word;
              tx_q      <= sel_word[7:0];
              hi_byte_q <= 1'b1;
            end
          end
          telemetry_pkg::ST_IDLE:
            state_q <= telemetry_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // line driver: ack low in write phases, data bits in reads
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      drive_low_q <= 1'b0;
    else if (start_det || stop_det)
      drive_low_q <= 1'b0;
    else if (scl_fall)
    begin
      if (bit_cnt_q == 4'h7 && state_q != telemetry_pkg::ST_RDATA &&
          state_q != telemetry_pkg::ST_IDLE)
        // address ack only when it matches us
        drive_low_q <= (state_q != telemetry_pkg::ST_ADDR) ||
                       (shreg_q[7:1] == SLAVE_ADDR);
      else if (bit_cnt_q == 4'h7)
        drive_low_q <= 1'b0; // master acks the read byte
      else if (bit_cnt_q == 4'h8)
      begin
        if (state_q == telemetry_pkg::ST_ADDR && shreg_q[7:1] == SLAVE_ADDR && rd_q)
          drive_low_q <= !sel_word[7];
        else if (state_q == telemetry_pkg::ST_RDATA && !nack_q)
          drive_low_q <= hi_byte_q ? !snap_q[15] : !sel_word[7];
        else
          drive_low_q <= 1'b0;
      end
      else if (state_q == telemetry_pkg::ST_RDATA)
        drive_low_q <= !tx_q[6];
      else
        drive_low_q <= 1'b0;
    end
  end

  // open drain: only ever pulls low, enable active low
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = !drive_low_q;

endmodule : channel_telemetry_readout

// *** channel_telemetry_readout_test.sv ***
// self-checking bench for the channel telemetry readout
`timescale 1ns/10ps
module channel_telemetry_readout_test;
  logic                             clk_in, rst_n_in, scl_in, hsda, sda_out, sda_oe_n_out, refresh_tick_out;
  wire logic                        sda_in;
  logic [3:0]                       class_scale_out;
  telemetry_pkg::chan_ctrl_t [3:0]  ctrl_in;
  telemetry_pkg::chan_meas_t [3:0]  meas_in;
  int                               miscompares, tests_run;
  logic [15:0]                      v;
  logic [2:0]                       wak;
  // open-drain data line with pull-up
  assign sda_in = hsda & (sda_oe_n_out | sda_out);
  channel_telemetry_readout #(.REFRESH_CYCLES(200)) dut_u (.clk_in, .rst_n_in, .scl_in, .sda_in,
    .sda_out, .sda_oe_n_out, .ctrl_in, .meas_in, .class_scale_out, .refresh_tick_out);
  serial_host_model host_u (.clk_in, .sda_in, .scl_out(scl_in), .sda_out(hsda));
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [2:0] ak;
    host_u.read16(c, v, ak);
    chk("read ack", {13'h0000, ak}, 16'h0000);
    chk($sformatf("cmd %h", c), v, e);
  endtask : rd
  // f holds powered, detect/class enable, detection valid, port enable
  task automatic setc(input int c, input telemetry_pkg::chan_mode_t m, input logic [3:0] f);
    @(posedge clk_in);
    ctrl_in[c] <= {m, f};
  endtask : setc
  // bounded wait for the refresh tick, then let the load land
  task automatic tick();
    int n;
    n = 0;
    // look after the edge so a control change made there is already seen
    @(negedge clk_in);
    while (refresh_tick_out !== 1'b1 && n < 300)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 300)
      miscompares++;
    repeat (2) @(posedge clk_in);
  endtask : tick
  task automatic cls(input logic [13:0] c);
    @(posedge clk_in);
    meas_in[0].cls <= c;
    meas_in[0].cls_done <= 1'b1;
    @(posedge clk_in);
    meas_in[0].cls_done <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : cls
  // hang guard, well above the expected run
  initial
  begin
    repeat (90000) @(posedge clk_in);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    rst_n_in = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      ctrl_in[i] = {telemetry_pkg::MODE_AUTO, 4'b0001};
      meas_in[i] = {14'(16'h3A5C + i), 14'(16'h2D80 + i), 1'b0, 14'h0000};
    end
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(8'h30 + 4 * i), 16'h0000);
      rd(8'(8'h32 + 4 * i), 16'h0000);
      setc(i, telemetry_pkg::MODE_AUTO, 4'b1111);
    end
    tick();
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(8'h30 + 4 * i), {2'b00, meas_in[i].cur});
      rd(8'(8'h32 + 4 * i), {2'b00, meas_in[i].volt});
    end
    host_u.write8(8'h30, 8'hFF, wak);
    chk("write ack", {13'h0000, wak}, 16'h0000);
    rd(8'h30, {2'b00, meas_in[0].cur});
    rd(8'h31, 16'h0000);
    meas_in[1].cur <= 14'h0155;
    tick();
    rd(8'h34, 16'h0155);
    // blanking cases on channel 0, then manual keeps the stored value
    setc(0, telemetry_pkg::MODE_OFF, 4'b1111);
    rd(8'h30, 16'h0000);
    setc(0, telemetry_pkg::MODE_SEMI, 4'b0011);
    rd(8'h30, 16'h0000);
    setc(0, telemetry_pkg::MODE_SEMI, 4'b0101);
    rd(8'h30, 16'h0000);
    setc(0, telemetry_pkg::MODE_MANUAL, 4'b0001);
    rd(8'h30, {2'b00, meas_in[0].cur});
    // class current survives an unpowered tick, cleared by a powered one
    setc(0, telemetry_pkg::MODE_SEMI, 4'b0111);
    cls(14'h1234);
    chk("class flag", {15'h0000, class_scale_out[0]}, 16'h0001);
    rd(8'h30, 16'h1234);
    tick();
    rd(8'h30, 16'h1234);
    setc(0, telemetry_pkg::MODE_AUTO, 4'b1111);
    tick();
    chk("class flag", {15'h0000, class_scale_out[0]}, 16'h0000);
    rd(8'h30, {2'b00, meas_in[0].cur});
    // port disable ends a class reading, voltage stays
    setc(0, telemetry_pkg::MODE_SEMI, 4'b0111);
    cls(14'h2ABC);
    setc(0, telemetry_pkg::MODE_SEMI, 4'b0110);
    repeat (2) @(posedge clk_in);
    chk("class flag", {15'h0000, class_scale_out[0]}, 16'h0000);
    rd(8'h30, 16'h0000);
    rd(8'h32, {2'b00, meas_in[0].volt});
    end_of_test();
  end
endmodule : channel_telemetry_readout_test

// *** serial_host_model.sv ***
// host-side serial master model for the telemetry readout
`timescale 1ns/10ps
module serial_host_model #(
  parameter logic [6:0] ADDR = 7'h20
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // bus idles released, both lines high through the pull-up
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // a quarter of the 64 ns link period; the link clock is free of clk_in
  task automatic ph();
    #16;
  endtask : ph
  // data moves only while SCL is low, sampled late in the high phase
  task automatic bt(input logic b, output logic r);
    sda_out <= b;
    ph();
    scl_out <= 1'b1;
    ph();
    ph();
    r = sda_in;
    scl_out <= 1'b0;
    ph();
  endtask : bt
  // SDA rises before SCL so a repeated start is never taken for a stop
  task automatic st();
    sda_out <= 1'b1;
    ph();
    scl_out <= 1'b1;
    ph();
    sda_out <= 1'b0;
    ph();
    scl_out <= 1'b0;
  endtask : st
  task automatic sp();
    sda_out <= 1'b0;
    ph();
    scl_out <= 1'b1;
    ph();
    sda_out <= 1'b1;
    ph();
  endtask : sp
  // eight bits MSB first, then the ninth bit a; k is the line seen there
  task automatic by(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    logic x;
    for (int i = 7; i >= 0; i--)
    begin
      bt(d[i], x);
      r[i] = x;
    end
    bt(a, k);
  endtask : by
  // ak gathers the acks the device owes: address, command, address again
  task automatic read16(input logic [7:0] c, output logic [15:0] v, output logic [2:0] ak);
    logic [7:0] u;
    logic       k;
    st();
    by({ADDR, 1'b0}, 1'b1, u, ak[2]);
    by(c, 1'b1, u, ak[1]);
    st();
    by({ADDR, 1'b1}, 1'b1, u, ak[0]);
    by(8'hFF, 1'b0, v[7:0], k);
    by(8'hFF, 1'b1, v[15:8], k);
    sp();
    @(posedge clk_in);
  endtask : read16
  // ak gathers the acks of address, command and data byte
  task automatic write8(input logic [7:0] c, input logic [7:0] d, output logic [2:0] ak);
    logic [7:0] u;
    st();
    by({ADDR, 1'b0}, 1'b1, u, ak[2]);
    by(c, 1'b1, u, ak[1]);
    by(d, 1'b1, u, ak[0]);
    sp();
    @(posedge clk_in);
  endtask : write8
endmodule : serial_host_model

// *** telemetry_pkg.sv ***
// shared constants and types for the channel telemetry readout
package telemetry_pkg;

  // ---------------------------------------------------------------
  // command codes of the two-byte telemetry registers
  // ---------------------------------------------------------------
  localparam logic [7:0] CH1_CURRENT_OFS = 8'h30;
  localparam logic [7:0] CH1_VOLTAGE_OFS = 8'h32;
  localparam logic [7:0] CH2_CURRENT_OFS = 8'h34;
  localparam logic [7:0] CH2_VOLTAGE_OFS = 8'h36;
  localparam logic [7:0] CH3_CURRENT_OFS = 8'h38;
  localparam logic [7:0] CH3_VOLTAGE_OFS = 8'h3A;
  localparam logic [7:0] CH4_CURRENT_OFS = 8'h3C;
  localparam logic [7:0] CH4_VOLTAGE_OFS = 8'h3E;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int          RESULT_W     = 14;
  localparam int          RESULT_MSB   = 13;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0]  UNMAPPED_VAL = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int REFRESH_MS     = 100;
  localparam int CLK_KHZ        = 200000;
  localparam int REFRESH_CYCLES = REFRESH_MS * CLK_KHZ;

  // channel operating mode, encoding arbitrary
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_SEMI   = 2'h2,
    MODE_AUTO   = 2'h3
  } chan_mode_t;

  // per-channel control state from the port controller
  typedef struct packed {
    chan_mode_t mode;
    logic       powered;
    logic       detclass_en;
    logic       det_valid;
    logic       port_en;
  } chan_ctrl_t;

  // per-channel converter results
  typedef struct packed {
    logic [RESULT_MSB:0] cur;
    logic [RESULT_MSB:0] volt;
    logic                cls_done;
    logic [RESULT_MSB:0] cls;
  } chan_meas_t;

  // serial slave phases, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ADDR  = 5'h02,
    ST_CMD   = 5'h04,
    ST_WDATA = 5'h08,
    ST_RDATA = 5'h10
  } ser_state_t;

endpackage : telemetry_pkg

// *** telemetry_sva.sv ***
// assertion checker for the channel telemetry readout ports
`timescale 1ns/10ps
module telemetry_sva #(
  parameter int NUM_CH         = 4,
  parameter int REFRESH_CYCLES = 200
) (
  input wire logic                                clk_in,
  input wire logic                                rst_n_in,
  input wire logic                                scl_in,
  input wire logic                                sda_out,
  input wire logic                                sda_oe_n_out,
  input wire telemetry_pkg::chan_ctrl_t [NUM_CH-1:0] ctrl_in,
  input wire telemetry_pkg::chan_meas_t [NUM_CH-1:0] meas_in,
  input wire logic [NUM_CH-1:0]                   class_scale_out,
  input wire logic                                refresh_tick_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [31:0] gap_q;
  logic        seen_q;
  // cycles since the last tick
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      gap_q <= '0;
    else
      gap_q <= refresh_tick_out ? '0 : gap_q + 32'd1;
  // the first period after reset is not judged
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      seen_q <= 1'b0;
    else if (refresh_tick_out)
      seen_q <= 1'b1;
  tick_period_a: assert property (seen_q |-> refresh_tick_out == (gap_q == 32'(REFRESH_CYCLES - 1)))
    else $error("refresh tick off period");
  tick_pulse_a: assert property (refresh_tick_out |=> !refresh_tick_out)
    else $error("refresh tick too long");
  sda_release_a: assert property ($rose(sda_oe_n_out) |-> !scl_in)
    else $error("data released while clock high");
  drive_scl_low_a: assert property ($fell(sda_oe_n_out) |-> !scl_in)
    else $error("data driven while clock high");
  cls_load_a: assert property (meas_in[0].cls_done && ctrl_in[0].port_en
    && !(refresh_tick_out && ctrl_in[0].powered) |=> class_scale_out[0])
    else $error("class flag not set");
  cls_clear_a: assert property (refresh_tick_out && ctrl_in[0].powered |=> !class_scale_out[0])
    else $error("class flag kept after conversion");
  port_off_a: assert property (!ctrl_in[0].port_en |=> !class_scale_out[0])
    else $error("class flag with port off");
  cls_rise_a: assert property ($rose(class_scale_out[0]) |-> $past(meas_in[0].cls_done))
    else $error("class flag without class result");
  cover property (meas_in[0].cls_done ##1 class_scale_out[0]);
  cover property (refresh_tick_out && ctrl_in[0].powered && class_scale_out[0]);
  cover property ($fell(sda_oe_n_out));
endmodule : telemetry_sva
bind channel_telemetry_readout telemetry_sva #(.NUM_CH(NUM_CH), .REFRESH_CYCLES(REFRESH_CYCLES)) sva_u (
  .clk_in, .rst_n_in, .scl_in, .sda_out, .sda_oe_n_out, .ctrl_in, .meas_in, .class_scale_out, .refresh_tick_out);
